// ---- design/sep_eeprom.sv ----
// serial eeprom slave: command decode, array, status and protection
// assumes host pins asynchronous to clock; mode 0 link far below clock
// Operation
// (R01) bits move most significant first
// (R02) first byte after select is opcode
// (R03) unknown opcode: ignore input, output off
// (R04) deselected: ignore input, output off
// (R05) pause pin freezes sequence, output off
// (R06) armed pin fall aborts pending status store
// (R07) set and clear write latch opcodes
// (R08) status fetch and status store opcodes
// (R09) array read and write opcodes
// (R10) latch clear at reset and after writes
// (R11) status bits busy and latch
// (R12) bits 4-6 zero; all ones while busy
// (R13) block guard bits select protected range
// (R14) guard and arm bits need timed write
// (R15) pin low and armed refuses status store
// (R16) array write needs latch, unguarded address
// (R17) sixteen address bits, input ignored after
// (R18) read auto-increments, wraps whole array
// (R19) programming starts on select rise at byte end
// (R20) while busy only status fetch works
// (R21) page write wraps low seven address bits
// (R22) write without latch is discarded
// (R23) sample on rising, shift on falling
// (R24) write cycle is a timer, then latch clears
`timescale 1ns/1ns
module sep_eeprom #(
    parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLE_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic writeProtectN,
    input wire logic pauseN,
    output logic serialOut,
    output logic serialOutEn
);
    import sep_pkg::*;

    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync3_r;
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            sync1_r <= 5'h1D;
            sync2_r <= 5'h1D;
            sync3_r <= 5'h1D;
        end
        else
        begin
            sync1_r <= {pauseN, writeProtectN, serialIn, serialClk, chipSelN};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    logic csLow, csFall, csRise, sckLow, sckRise, sckFall;
    logic siS, wpLow, wpFall, pauseLow;
    assign csLow = !sync2_r[0];
    assign csFall = sync3_r[0] && !sync2_r[0];
    assign csRise = !sync3_r[0] && sync2_r[0];
    assign sckLow = !sync2_r[1];
    assign sckRise = !sync3_r[1] && sync2_r[1];
    assign sckFall = sync3_r[1] && !sync2_r[1];
    assign siS = sync2_r[2];
    assign wpLow = !sync2_r[3];
    assign wpFall = sync3_r[3] && !sync2_r[3];
    assign pauseLow = !sync2_r[4];

    // ----------------------------------------
    // array, page buffer
    // ----------------------------------------
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pageBuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageVal_r;
    logic [ADDR_W-PAGE_AW-1:0] pageHi_r;

    function automatic logic guarded(input logic [15:0] a,
                                     input logic [1:0] g);
        case (g)
            2'h0: guarded = 1'b0;
            2'h1: guarded = (a >= GUARD_QUARTER_BASE);
            2'h2: guarded = (a >= GUARD_HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction

    // ----------------------------------------
    // sequence state
    // ----------------------------------------
    sep_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic rdMode_r, rdMode_nxt;
    logic drive_r, drive_nxt;
    logic soBit_r, soBit_nxt;
    logic soEn_r, soEn_nxt;
    logic holdAct_r, holdAct_nxt;
    logic wel_r, wel_nxt;
    logic arm_r, arm_nxt;
    logic [1:0] guard_r, guard_nxt;
    logic busy_r, busy_nxt;
    logic [TIMER_W-1:0] timer_r, timer_nxt;
    logic pendArr_r, pendArr_nxt;
    logic pendSt_r, pendSt_nxt;
    logic [7:0] stNew_r, stNew_nxt;
    logic swrReady_r, swrReady_nxt;
    logic abort_r, abort_nxt;
    logic anyByte_r, anyByte_nxt;
    logic bufClr, bufWr, commitArr;
    logic rise, fall;
    logic [7:0] byteIn, statusView, outByte, opc;

    assign statusView = busy_r ? STATUS_BUSY_READ :
        {arm_r, 3'h0, guard_r, wel_r, 1'b0}; // R11 R12
    assign serialOut = soBit_r;
    assign serialOutEn = soEn_r;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        rdMode_nxt = rdMode_r;
        drive_nxt = drive_r;
        soBit_nxt = soBit_r;
        wel_nxt = wel_r;
        arm_nxt = arm_r;
        guard_nxt = guard_r;
        busy_nxt = busy_r;
        timer_nxt = timer_r;
        pendArr_nxt = pendArr_r;
        pendSt_nxt = pendSt_r;
        stNew_nxt = stNew_r;
        swrReady_nxt = swrReady_r;
        abort_nxt = abort_r;
        anyByte_nxt = anyByte_r;
        bufClr = 1'b0;
        bufWr = 1'b0;
        commitArr = 1'b0;
        outByte = 8'h00;
        byteIn = {rx_r[6:0], siS}; // R01
        opc = byteIn & OP_MASK;
        holdAct_nxt = sckLow ? (csLow && pauseLow) : holdAct_r; // R05
        rise = sckRise && !holdAct_r; // R05 R23
        fall = sckFall && !holdAct_r; // R05 R23
        // self-timed write cycle
        if (busy_r)
        begin
            if (timer_r == '0)
            begin
                busy_nxt = 1'b0; // R24
                wel_nxt = 1'b0; // R10
                commitArr = pendArr_r;
                if (pendSt_r)
                begin
                    arm_nxt = stNew_r[ST_ARM_BIT]; // R14
                    guard_nxt = stNew_r[ST_GUARD_HI_BIT:ST_GUARD_LO_BIT];
                end
                pendArr_nxt = 1'b0;
                pendSt_nxt = 1'b0;
            end
            else
            begin
                timer_nxt = timer_r - 1'b1;
            end
        end
        if (csFall)
        begin
            state_nxt = S_OPC; // R02
            cnt_nxt = 4'h0;
            drive_nxt = 1'b0;
            abort_nxt = 1'b0;
            swrReady_nxt = 1'b0;
            anyByte_nxt = 1'b0;
        end
        else if (!csLow)
        begin
            state_nxt = S_STBY; // R04 R22
            drive_nxt = 1'b0;
            if (csRise && !busy_r)
            begin
                if (state_r == S_WR && anyByte_r && cnt_r[2:0] == 3'h0
                    && wel_r)
                begin
                    busy_nxt = 1'b1; // R19 R16
                    pendArr_nxt = 1'b1;
                    timer_nxt = TIMER_W'(WRITE_CYCLES - 1); // R24
                end
                else if (swrReady_r && cnt_r[2:0] == 3'h0 && wel_r
                    && !(wpLow && arm_r) && !abort_r)
                begin
                    busy_nxt = 1'b1; // R15 R06 R19 R14
                    pendSt_nxt = 1'b1;
                    timer_nxt = TIMER_W'(WRITE_CYCLES - 1);
                end
            end
        end
        else
        begin
            case (state_r)
                S_OPC:
                begin
                    if (rise)
                    begin
                        rx_nxt = byteIn;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r[2:0] == 3'h7)
                        begin
                            cnt_nxt = 4'h0;
                            state_nxt = S_IGN; // R03
                            if (opc == OP_STATUS_FETCH)
                            begin
                                state_nxt = S_SRD; // R08 R20
                            end
                            else if (!busy_r) // R20
                            begin
                                case (opc)
                                    OP_SET_WRITE_LATCH: wel_nxt = 1'b1; // R07
                                    OP_CLEAR_WRITE_LATCH: wel_nxt = 1'b0; // R07
                                    OP_STATUS_STORE: state_nxt = S_SWR; // R08
                                    OP_ARRAY_READ:
                                    begin
                                        state_nxt = S_ADDR; // R09
                                        rdMode_nxt = 1'b1;
                                    end
                                    OP_ARRAY_WRITE:
                                    begin
                                        state_nxt = wel_r ? S_ADDR : S_IGN; // R22
                                        rdMode_nxt = 1'b0;
                                    end
                                    default: state_nxt = S_IGN; // R03
                                endcase
                            end
                        end
                    end
                end
                S_ADDR:
                begin
                    if (rise)
                    begin
                        addr_nxt = {addr_r[14:0], siS}; // R17
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == 4'hF)
                        begin
                            cnt_nxt = 4'h0;
                            state_nxt = rdMode_r ? S_RD : S_WR;
                            bufClr = !rdMode_r;
                        end
                    end
                end
                S_RD, S_SRD:
                begin
                    if (fall) // R17 R23
                    begin
                        drive_nxt = 1'b1;
                        cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
                        if (cnt_r[2:0] == 3'h0)
                        begin
                            outByte = (state_r == S_RD) ? mem[addr_r]
                                                        : statusView; // R08
                            soBit_nxt = outByte[7]; // R01
                            tx_nxt = {outByte[6:0], 1'b0};
                            if (state_r == S_RD)
                            begin
                                addr_nxt = addr_r + 16'h0001; // R18
                            end
                        end
                        else
                        begin
                            soBit_nxt = tx_r[7];
                            tx_nxt = {tx_r[6:0], 1'b0};
                        end
                    end
                end
                S_WR:
                begin
                    if (rise)
                    begin
                        rx_nxt = byteIn;
                        cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
                        if (cnt_r[2:0] == 3'h7)
                        begin
                            anyByte_nxt = 1'b1;
                            bufWr = !guarded(addr_r, guard_r); // R13 R16
                            addr_nxt = {addr_r[15:7],
                                        addr_r[6:0] + 7'h01}; // R21
                        end
                    end
                end
                S_SWR:
                begin
                    if (rise)
                    begin
                        rx_nxt = byteIn;
                        cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
                        if (cnt_r[2:0] == 3'h7)
                        begin
                            stNew_nxt = byteIn; // R08
                            swrReady_nxt = 1'b1;
                            state_nxt = S_IGN;
                        end
                    end
                end
                default:
                begin
                    state_nxt = state_r; // R03
                end
            endcase
        end
        if (wpFall && csLow && arm_r)
        begin
            abort_nxt = 1'b1; // R06
        end
        soEn_nxt = drive_nxt && csLow && !csFall && !holdAct_nxt; // R04 R05
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_r <= S_STBY;
            cnt_r <= 4'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= 16'h0000;
            rdMode_r <= 1'b0;
            drive_r <= 1'b0;
            soBit_r <= 1'b0;
            soEn_r <= 1'b0;
            holdAct_r <= 1'b0;
            wel_r <= 1'b0; // R10
            arm_r <= PIN_PROTECT_ARM_RST;
            guard_r <= BLOCK_GUARD_RST;
            busy_r <= 1'b0;
            timer_r <= '0;
            pendArr_r <= 1'b0;
            pendSt_r <= 1'b0;
            stNew_r <= 8'h00;
            swrReady_r <= 1'b0;
            abort_r <= 1'b0;
            anyByte_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            rdMode_r <= rdMode_nxt;
            drive_r <= drive_nxt;
            soBit_r <= soBit_nxt;
            soEn_r <= soEn_nxt;
            holdAct_r <= holdAct_nxt;
            wel_r <= wel_nxt;
            arm_r <= arm_nxt;
            guard_r <= guard_nxt;
            busy_r <= busy_nxt;
            timer_r <= timer_nxt;
            pendArr_r <= pendArr_nxt;
            pendSt_r <= pendSt_nxt;
            stNew_r <= stNew_nxt;
            swrReady_r <= swrReady_nxt;
            abort_r <= abort_nxt;
            anyByte_r <= anyByte_nxt;
        end
    end

    // ----------------------------------------
    // page buffer fill and array commit
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pageVal_r <= '0;
            pageHi_r <= '0;
        end
        else if (bufClr)
        begin
            pageVal_r <= '0;
            pageHi_r <= addr_nxt[15:7];
        end
        else if (bufWr)
        begin
            pageBuf[addr_r[6:0]] <= rx_nxt; // R21
            pageVal_r[addr_r[6:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (commitArr)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (pageVal_r[i])
                begin
                    mem[{pageHi_r, PAGE_AW'(i)}] <= pageBuf[i];
                end
            end
        end
    end
endmodule

// ---- design/sep_pkg.sv ----
// constants, opcodes and state codes of the serial eeprom slave
// assumes a 25 MHz system clock that samples every link pin
package sep_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYC = CLK_HZ / 1000 * WRITE_CYCLE_MS;
    localparam int TIMER_W = 20;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int PAGE_AW = 7;
    localparam int PAGE_BYTES = 128;
    localparam int MEM_BYTES = 65536;
    localparam logic [15:0] GUARD_QUARTER_BASE = 16'hC000;
    localparam logic [15:0] GUARD_HALF_BASE = 16'h8000;
    // ----------------------------------------
    // opcodes, bit 3 masked off
    // ----------------------------------------
    localparam logic [7:0] OP_MASK = 8'hF7;
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    // ----------------------------------------
    // status register layout and reset values
    // ----------------------------------------
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_GUARD_LO_BIT = 2;
    localparam int ST_GUARD_HI_BIT = 3;
    localparam int ST_ARM_BIT = 7;
    localparam logic [7:0] STATUS_BUSY_READ = 8'hFF;
    localparam logic PIN_PROTECT_ARM_RST = 1'b0;
    localparam logic [1:0] BLOCK_GUARD_RST = 2'h0;
    // ----------------------------------------
    // sequence states
    // ----------------------------------------
    typedef enum logic [6:0] {
        S_STBY = 7'b0000001,
        S_OPC  = 7'b0000010,
        S_ADDR = 7'b0000100,
        S_RD   = 7'b0001000,
        S_WR   = 7'b0010000,
        S_SRD  = 7'b0100000,
        S_SWR  = 7'b1000000
    } sep_state_e;
    localparam sep_state_e S_IGN = S_STBY;
endpackage

// ---- bench/sep_eeprom_chk.sv ----
// concurrent checks on the link pins of the serial eeprom slave
// assumes one clock samples every pin; bound to each sep_eeprom
`timescale 1ns/1ns
module sep_eeprom_chk #(
    parameter int WRITE_CYCLES = 125000
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic writeProtectN,
    input wire logic pauseN,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    logic clkQ_r;
    logic [5:0] riseCnt_r;
    logic [5:0] riseCnt_nxt;
    // ----------------------------------------
    // link clock rises seen in this frame
    // ----------------------------------------
    always_comb
    begin
        riseCnt_nxt = riseCnt_r;
        if (chipSelN)
            riseCnt_nxt = 6'h00;
        else if (serialClk && !clkQ_r && riseCnt_r != 6'h3F)
            riseCnt_nxt = riseCnt_r + 6'h01;
    end
    always_ff @(posedge clock)
    begin
        clkQ_r <= serialClk;
        riseCnt_r <= riseCnt_nxt;
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    deselect_off_a:
        assert property (chipSelN [*6] |-> !serialOutEn)
        else $error("output driven while deselected");
    select_rise_a:
        assert property ($rose(chipSelN) |-> ##[1:5] !serialOutEn)
        else $error("output not released after deselect");
    pause_off_a:
        assert property ((!pauseN && !serialClk && !chipSelN) [*8]
            |-> !serialOutEn)
        else $error("output driven during pause");
    pause_resume_a:
        assert property ($rose(serialOutEn)
            |-> !chipSelN && $past(pauseN, 3))
        else $error("output enabled while paused or deselected");
    out_hold_a:
        assert property ((serialClk && !chipSelN) [*3]
            |-> $stable(serialOut))
        else $error("output changed while link clock high");
    en_on_low_a:
        assert property ($rose(serialOutEn) |-> !serialClk)
        else $error("output enabled outside clock low");
    opcode_first_a:
        assert property ($rose(serialOutEn) |-> riseCnt_r >= 6'h08)
        else $error("output enabled before a whole opcode");
    reset_quiet_a:
        assert property (disable iff (1'b0) !rstn |=> !serialOutEn)
        else $error("output driven in reset");
endmodule
bind sep_eeprom sep_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES))
    sep_eeprom_chk_inst (
    .clock(clock), .rstn(rstn), .chipSelN(chipSelN),
    .serialClk(serialClk), .serialIn(serialIn),
    .writeProtectN(writeProtectN), .pauseN(pauseN),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
);

// ---- bench/sep_host_model.sv ----
// host side of the serial link: mode 0 frames, bytes and a pause
// assumes one caller at a time; 320 ns link bit period
`timescale 1ns/1ns
module sep_host_model (
    output logic chipSelN,
    output logic serialClk,
    output logic serialIn,
    output logic pauseN,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    logic sawEn;
    logic pauseEn;
    // ----------------------------------------
    // frame tasks
    // ----------------------------------------
    initial
    begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
        pauseN = 1'b1;
        sawEn = 1'b0;
    end
    task automatic open_frame();
        #13 chipSelN = 1'b0;
        sawEn = 1'b0;
        #200;
    endtask
    task automatic xfer(input logic [7:0] tx, input int nb,
        output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--)
        begin
            serialIn = tx[i];
            #160 serialClk = 1'b1;
            rx[i] = serialOut;
            sawEn = sawEn | serialOutEn;
            #160 serialClk = 1'b0;
        end
    endtask
    task automatic close_frame();
        #100 chipSelN = 1'b1;
        serialIn = ~serialIn;
        #400;
    endtask
    task automatic hold_link();
        #80 pauseN = 1'b0;
        serialIn = ~serialIn;
        #160 serialClk = 1'b1;
        #160 serialClk = 1'b0;
        #440 pauseEn = serialOutEn;
        pauseN = 1'b1;
        #160;
    endtask
endmodule

// ---- bench/sep_eeprom_tb_top.sv ----
// self-checking bench of the serial eeprom slave through its link pins
// assumes sep_host_model makes frames; write cycle shortened
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("ERROR t=%0t got %h exp %h", $time, g, e); \
        end \
    end
module sep_eeprom_tb_top;
    localparam int WCYC = 1000;
    localparam logic [15:0] GA [3] = '{16'hC000, 16'h8000, 16'h0000};
    logic clock, rstn, writeProtectN, chipSelN, serialClk;
    logic serialIn, pauseN, serialOut, serialOutEn;
    logic [7:0] st;
    logic [7:0] gMem [3];
    int n_fail;
    int checks_done;
    // ----------------------------------------
    // design, host and clock
    // ----------------------------------------
    sep_eeprom #(.WRITE_CYCLES(WCYC)) sep_eeprom_inst (
        .clock(clock), .rstn(rstn), .chipSelN(chipSelN),
        .serialClk(serialClk), .serialIn(serialIn),
        .writeProtectN(writeProtectN), .pauseN(pauseN),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    sep_host_model sep_host_model_inst (
        .chipSelN(chipSelN), .serialClk(serialClk),
        .serialIn(serialIn), .pauseN(pauseN),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        repeat (95000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end
    // ----------------------------------------
    // link tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic done_test(input string s);
        $display("test %s finished", s);
    endtask
    task automatic pin(input logic v);
        @(negedge clock);
        writeProtectN = v;
    endtask
    task automatic xb(input logic [7:0] b);
        logic [7:0] r;
        sep_host_model_inst.xfer(b, 8, r);
    endtask
    task automatic frame(input logic [7:0] op, input logic [7:0] d,
        input int n);
        sep_host_model_inst.open_frame();
        xb(op);
        if (n > 0)
            xb(d);
        sep_host_model_inst.close_frame();
    endtask
    task automatic status_fetch_cmd();
        sep_host_model_inst.open_frame();
        xb(8'h05);
        sep_host_model_inst.xfer(8'h00, 8, st);
        sep_host_model_inst.close_frame();
    endtask
    task automatic chk_st(input logic [7:0] e);
        status_fetch_cmd();
        `CHK(st, e)
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        status_fetch_cmd();
        while (st[0] !== 1'b0 && k < 40)
        begin
            status_fetch_cmd();
            k++;
        end
        if (st[0] !== 1'b0)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input int n);
        sep_host_model_inst.open_frame();
        xb(8'h02);
        xb(a[15:8]);
        xb(a[7:0]);
        for (int i = 0; i < n; i++)
            xb(d + 8'(i));
        sep_host_model_inst.close_frame();
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d,
        input int n);
        frame(8'h06, 8'h00, 0);
        wr(a, d, n);
        wait_ready();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e0,
        input logic [7:0] e1, input int n);
        logic [7:0] r [2];
        sep_host_model_inst.open_frame();
        xb(8'h03);
        xb(a[15:8]);
        xb(a[7:0]);
        for (int i = 0; i < 2; i++)
            sep_host_model_inst.xfer(8'hA5, 8, r[i]);
        sep_host_model_inst.close_frame();
        if (n > 0)
            `CHK(r[0], e0)
        if (n > 1)
            `CHK(r[1], e1)
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        rstn = 1'b0;
        writeProtectN = 1'b1;
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        chk_st(8'h00);
        frame(8'h06, 8'h00, 0);
        chk_st(8'h02);
        pin(1'b0);
        frame(8'h04, 8'h00, 0);
        chk_st(8'h00);
        pin(1'b1);
        frame(8'h0E, 8'h00, 0);
        chk_st(8'h02);
        frame(8'h0C, 8'h00, 0);
        chk_st(8'h00);
        frame(8'h15, 8'h05, 1);
        `CHK(sep_host_model_inst.sawEn, 1'b0)
        `CHK(serialOutEn, 1'b0)
        done_test("latch");
        prog(16'h0100, 8'h11, 2);
        wr(16'h0100, 8'h22, 1);
        chk_st(8'h00);
        rd(16'h0100, 8'h11, 8'h12, 2);
        frame(8'h06, 8'h00, 0);
        wr(16'h127E, 8'hA0, 4);
        chk_st(8'hFF);
        rd(16'h127E, 8'h00, 8'h00, 0);
        `CHK(sep_host_model_inst.sawEn, 1'b0)
        wait_ready();
        chk_st(8'h00);
        rd(16'h127E, 8'hA0, 8'hA1, 2);
        rd(16'h1200, 8'hA2, 8'hA3, 2);
        prog(16'hFFFF, 8'h5A, 1);
        prog(16'h0000, 8'hC3, 1);
        rd(16'hFFFF, 8'h5A, 8'hC3, 2);
        frame(8'h06, 8'h00, 0);
        sep_host_model_inst.open_frame();
        xb(8'h02);
        xb(8'h01);
        xb(8'h00);
        xb(8'h77);
        sep_host_model_inst.xfer(8'h99, 4, st);
        sep_host_model_inst.close_frame();
        chk_st(8'h02);
        rd(16'h0100, 8'h11, 8'h12, 2);
        done_test("array");
        for (int bp = 0; bp < 4; bp++)
        begin
            frame(8'h06, 8'h00, 0);
            frame(8'h01, 8'(bp << 2), 1);
            wait_ready();
            chk_st(8'(bp << 2));
            for (int i = 0; i < 3; i++)
            begin
                prog(GA[i], 8'(bp * 16 + i), 1);
                if (bp <= i)
                    gMem[i] = 8'(bp * 16 + i);
                rd(GA[i], gMem[i], 8'h00, 1);
            end
        end
        frame(8'h06, 8'h00, 0);
        frame(8'h01, 8'h00, 1);
        wait_ready();
        done_test("guard");
        frame(8'h01, 8'h80, 1);
        chk_st(8'h00);
        frame(8'h06, 8'h00, 0);
        frame(8'h01, 8'h80, 1);
        wait_ready();
        chk_st(8'h80);
        pin(1'b0);
        frame(8'h06, 8'h00, 0);
        frame(8'h01, 8'h00, 1);
        frame(8'h04, 8'h00, 0);
        chk_st(8'h80);
        pin(1'b1);
        frame(8'h06, 8'h00, 0);
        sep_host_model_inst.open_frame();
        xb(8'h01);
        xb(8'h00);
        pin(1'b0);
        repeat (4) @(negedge clock);
        writeProtectN = 1'b1;
        sep_host_model_inst.close_frame();
        frame(8'h04, 8'h00, 0);
        chk_st(8'h80);
        sep_host_model_inst.open_frame();
        xb(8'h05);
        sep_host_model_inst.hold_link();
        sep_host_model_inst.xfer(8'h00, 8, st);
        sep_host_model_inst.close_frame();
        `CHK(st, 8'h80)
        `CHK(sep_host_model_inst.pauseEn, 1'b0)
        frame(8'h06, 8'h00, 0);
        frame(8'h01, 8'h00, 1);
        wait_ready();
        chk_st(8'h00);
        done_test("protect");
        tally_and_finish();
    end
endmodule
